//--- design/ebm_sequencer.sv
// Mode sequencer of the energy buffer: register file, state, ready pin.
// Assumes a decoded register port from the serial front end and level
// indications from the converter, all synchronous to clk_sys.
`timescale 1ns/100ps
`include "ebm_params.svh"

module ebm_sequencer
  import ebm_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Register access from the serial interface
  input  wire ebm_reg_req_t reg_req,
  output      logic [7:0]   reg_rdata_ff,
  // Converter indications
  input  wire ebm_analog_t  analog_in,
  // Pins and converter controls
  output      logic         ready_pin_ff,
  output      logic         regulated_output_en_ff,
  output      ebm_state_t   state_ff,
  output      ebm_cfg_t     cfg_ff
);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic       mode_wr;
  logic       standby_wr;
  logic       cont_wr;
  logic [7:0] mode_ff;
  logic       ew_sticky_ff;
  logic       alrm_sticky_ff;
  logic [7:0] status_byte;
  ebm_state_t nxt_state;
  logic       ready_lvl;

  assign mode_wr    = reg_req.wr_en && (reg_req.addr == `EBM_ADDR_MODE);
  assign standby_wr = mode_wr &&
                      (reg_req.wdata[`EBM_MODE_CMD_MSB:0] == `EBM_MODE_STANDBY);
  assign cont_wr    = mode_wr &&
                      (reg_req.wdata[`EBM_MODE_CMD_MSB:0] == `EBM_MODE_CONT);
  // Ready means the store is charged; in on-demand this coincides with active
  assign ready_lvl  = (state_ff == EBM_ST_READY) || (state_ff == EBM_ST_ACTIVE);

  // ----------------------------------------------------------------------
  // Mode and configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_ff <= `EBM_RST_BYTE;
    end else if (mode_wr) begin
      mode_ff <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_ff.volt     <= `EBM_RST_VOLT;
      cfg_ff.batt_cfg <= `EBM_RST_BATT_CFG;
      cfg_ff.ew_cfg   <= `EBM_RST_EW_CFG;
      cfg_ff.cap_max  <= `EBM_RST_CAP_MAX;
      cfg_ff.opt_marg <= `EBM_RST_OPT_MARG;
    end else if (reg_req.wr_en) begin
      case (reg_req.addr)
        `EBM_ADDR_VOLT:     cfg_ff.volt     <= reg_req.wdata;
        `EBM_ADDR_BATT_CFG: cfg_ff.batt_cfg <= reg_req.wdata;
        `EBM_ADDR_EW_CFG:   cfg_ff.ew_cfg   <= reg_req.wdata;
        `EBM_ADDR_CAP_MAX:  cfg_ff.cap_max  <= reg_req.wdata;
        `EBM_ADDR_OPT_MARG: cfg_ff.opt_marg <= reg_req.wdata;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      EBM_ST_STANDBY: begin
        if (mode_wr && (reg_req.wdata[`EBM_MODE_OD_BIT] || reg_req.wdata[`EBM_MODE_CM_BIT])) begin
          nxt_state = EBM_ST_CHARGE;
        end
      end
      EBM_ST_CHARGE: begin
        // On-demand goes straight to regulation once the store is full
        if (analog_in.cap_charged) begin
          nxt_state = mode_ff[`EBM_MODE_OD_BIT] ? EBM_ST_ACTIVE : EBM_ST_READY;
        end
      end
      EBM_ST_READY: begin
        if (mode_wr && reg_req.wdata[`EBM_MODE_ACT_BIT]) begin
          nxt_state = EBM_ST_ACTIVE;
        end
      end
      EBM_ST_ACTIVE: begin
        if (cont_wr) begin
          nxt_state = EBM_ST_CHARGE;
        end
      end
      default: nxt_state = EBM_ST_STANDBY;
    endcase
    // Standby command overrides every state
    if (standby_wr) begin
      nxt_state = EBM_ST_STANDBY;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff <= EBM_ST_STANDBY;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------------
  // Sticky indications, cleared by the standby command
  // ----------------------------------------------------------------------
  // A new event in the clearing cycle wins so it is never lost
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ew_sticky_ff <= 1'b0;
    end else if (analog_in.depletion_warning) begin
      ew_sticky_ff <= 1'b1;
    end else if (standby_wr) begin
      ew_sticky_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      alrm_sticky_ff <= 1'b0;
    end else if (analog_in.regulation_lost && (state_ff == EBM_ST_ACTIVE)) begin
      alrm_sticky_ff <= 1'b1;
    end else if (standby_wr) begin
      alrm_sticky_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------------
  // Warning under load pulls the ready pin low so a GPIO alone suffices
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ready_pin_ff <= 1'b0;
    end else begin
      ready_pin_ff <= ready_lvl &&
                      !((state_ff == EBM_ST_ACTIVE) && analog_in.depletion_warning);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      regulated_output_en_ff <= 1'b0;
    end else begin
      regulated_output_en_ff <= (nxt_state == EBM_ST_ACTIVE) ||
                                !cfg_ff.batt_cfg[`EBM_HIZ_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_comb begin
    status_byte = `EBM_RST_BYTE;
    status_byte[`EBM_ST_RDY_BIT]    = ready_lvl;
    status_byte[`EBM_ST_EW_BIT]     = ew_sticky_ff;
    status_byte[`EBM_ST_ALRM_BIT]   = alrm_sticky_ff;
    status_byte[`EBM_ST_LOWBAT_BIT] = analog_in.battery_low;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata_ff <= `EBM_RST_BYTE;
    end else if (reg_req.rd_en) begin
      case (reg_req.addr)
        `EBM_ADDR_STATUS:   reg_rdata_ff <= status_byte;
        `EBM_ADDR_MODE:     reg_rdata_ff <= mode_ff;
        `EBM_ADDR_VOLT:     reg_rdata_ff <= cfg_ff.volt;
        `EBM_ADDR_BATT_CFG: reg_rdata_ff <= cfg_ff.batt_cfg;
        `EBM_ADDR_EW_CFG:   reg_rdata_ff <= cfg_ff.ew_cfg;
        `EBM_ADDR_CAP_MAX:  reg_rdata_ff <= cfg_ff.cap_max;
        `EBM_ADDR_OPT_MARG: reg_rdata_ff <= cfg_ff.opt_marg;
        default:            reg_rdata_ff <= `EBM_RST_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_standby_cmd;
    standby_wr;
  endsequence

  // Standby wins over the full-store event, so it is kept out of the trigger
  sequence s_charged_od;
    (state_ff == EBM_ST_CHARGE) && analog_in.cap_charged && mode_ff[`EBM_MODE_OD_BIT] &&
    !standby_wr;
  endsequence

  // Ready pin lags the state by one cycle, so it is checked one step later
  a_standby_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_standby_cmd |=> (state_ff == EBM_ST_STANDBY) ##1 !ready_pin_ff)
    else $error("standby command not obeyed");

  a_od_to_active: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_charged_od |=> (state_ff == EBM_ST_ACTIVE) ##1
    (ready_pin_ff || $past(analog_in.depletion_warning)))
    else $error("on-demand charge did not reach active with ready");

  a_ready_status: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ready_pin_ff |-> $past(status_byte[`EBM_ST_RDY_BIT]))
    else $error("ready pin high without ready status");

  a_ew_on_pin: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_ff == EBM_ST_ACTIVE) && analog_in.depletion_warning |=> !ready_pin_ff && ew_sticky_ff)
    else $error("warning under load not shown on pin and status");

  a_alarm_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    alrm_sticky_ff && !standby_wr |=> alrm_sticky_ff)
    else $error("alarm dropped without standby command");

  a_lowbat_runs: assert property (@(posedge clk_sys) disable iff (!rst_n)
    analog_in.battery_low && (state_ff == EBM_ST_ACTIVE) && !mode_wr
    |=> state_ff == EBM_ST_ACTIVE)
    else $error("low battery stopped operation");

  // Enable is registered from the next state and the current hiz bit
  a_hiz_output: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_ff.batt_cfg[`EBM_HIZ_BIT] && (nxt_state != EBM_ST_ACTIVE) |=> !regulated_output_en_ff)
    else $error("output enabled outside active with hiz set");

  localparam logic [7:0] RST_BATT_CFG = `EBM_RST_BATT_CFG;

  a_ich_default: assert property (@(posedge clk_sys)
    !rst_n |=> cfg_ff.batt_cfg[`EBM_ICH_MSB:`EBM_ICH_LSB] ==
               RST_BATT_CFG[`EBM_ICH_MSB:`EBM_ICH_LSB])
    else $error("charge current field not at default after reset");

endmodule

//--- design/ebm_params.svh
// Constants for the energy buffer mode sequencer: offsets, fields, resets.
// Assumes inclusion by bare name from the package and the sequencer module.
`ifndef EBM_PARAMS_SVH
`define EBM_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define EBM_ADDR_STATUS     8'h00
`define EBM_ADDR_MODE       8'h08
`define EBM_ADDR_VOLT       8'h09
`define EBM_ADDR_BATT_CFG   8'h10
`define EBM_ADDR_EW_CFG     8'h11
`define EBM_ADDR_CAP_MAX    8'h12
`define EBM_ADDR_OPT_MARG   8'h13

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EBM_MODE_OD_BIT     0
`define EBM_MODE_CM_BIT     1
`define EBM_MODE_ACT_BIT    2
`define EBM_MODE_CMD_MSB    2
`define EBM_MODE_STANDBY    3'h0
`define EBM_MODE_CONT       3'h2
`define EBM_ST_RDY_BIT      0
`define EBM_ST_EW_BIT       1
`define EBM_ST_ALRM_BIT     2
`define EBM_ST_LOWBAT_BIT   3
`define EBM_HIZ_BIT         4
`define EBM_ICH_MSB         7
`define EBM_ICH_LSB         5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define EBM_RST_BYTE        8'h00
`define EBM_RST_BATT_CFG    8'h60
`define EBM_RST_VOLT        8'h00
`define EBM_RST_EW_CFG      8'h00
`define EBM_RST_CAP_MAX     8'h00
`define EBM_RST_OPT_MARG    8'h00

`endif

//--- design/ebm_pkg.sv
// Types shared by the energy buffer mode sequencer.
// Assumes ebm_params.svh is on the include path.
`include "ebm_params.svh"

package ebm_pkg;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    EBM_ST_STANDBY = 2'b00,
    EBM_ST_CHARGE  = 2'b01,
    EBM_ST_READY   = 2'b10,
    EBM_ST_ACTIVE  = 2'b11
  } ebm_state_t;

  // ----------------------------------------------------------------------
  // Register access and configuration bundles
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ebm_reg_req_t;

  typedef struct packed {
    logic [7:0] volt;
    logic [7:0] batt_cfg;
    logic [7:0] ew_cfg;
    logic [7:0] cap_max;
    logic [7:0] opt_marg;
  } ebm_cfg_t;

  typedef struct packed {
    logic cap_charged;
    logic depletion_warning;
    logic regulation_lost;
    logic battery_low;
  } ebm_analog_t;

endpackage

//--- verification/ebm_host_model.sv
// Host controller model: drives the decoded register port of the sequencer.
// Assumes the bench calls its tasks; requests launch on falling edges.
`timescale 1ns/100ps

module ebm_host_model
  import ebm_pkg::*;
#(
  parameter int BOOT_CYC = 16
)
(
  // Clock
  clk_sys,
  // Register port
  reg_req,
  reg_rdata_ff
);
  input  wire logic         clk_sys;
  output      ebm_reg_req_t reg_req;
  input  wire logic [7:0]   reg_rdata_ff;

  initial reg_req = '0;

  // -----------------------------------------------------------------
  // Register cycles
  // -----------------------------------------------------------------
  // The device never blocks early access, so the host keeps the wait
  task automatic boot_wait();
    repeat (BOOT_CYC) @(negedge clk_sys);
  endtask

  // Strobe stands across one rising edge; released lines show inverted data
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input int gap);
    @(negedge clk_sys);
    reg_req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys);
    reg_req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
    repeat (gap) @(negedge clk_sys);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'hA5};
    @(negedge clk_sys);
    reg_req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: 8'h5A};
    @(negedge clk_sys);
    d = reg_rdata_ff;
  endtask
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the energy buffer mode sequencer.
// Assumes ebm_pkg and ebm_params.svh compiled first; host model drives registers.
`timescale 1ns/100ps
`include "ebm_params.svh"

module tb_top
  import ebm_pkg::*;
;
  logic         clk_sys;
  logic         rst_n;
  ebm_reg_req_t reg_req;
  logic [7:0]   rdata;
  ebm_analog_t  analog_in;
  logic         ready_pin;
  logic         out_en;
  ebm_state_t   state;
  ebm_cfg_t     cfg;
  logic [7:0]   rd;
  int           error_cnt = 0;
  int           num_checks = 0;

  ebm_sequencer u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata_ff(rdata), .analog_in(analog_in), .ready_pin_ff(ready_pin),
    .regulated_output_en_ff(out_en), .state_ff(state), .cfg_ff(cfg));

  ebm_host_model #(.BOOT_CYC(16)) u_host (.clk_sys(clk_sys), .reg_req(reg_req),
    .reg_rdata_ff(rdata));

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_reset();
    chk(cfg, {8'h00, 8'h60, 8'h00, 8'h00, 8'h00});
    chk(state, EBM_ST_STANDBY);
    chk(out_en, 1'b1);
    u_host.rd_reg(`EBM_ADDR_BATT_CFG, rd);
    chk(rd[7:5], 3'h3);
    u_host.wr_reg(`EBM_ADDR_STATUS, 8'hFF, 0);
    u_host.rd_reg(`EBM_ADDR_STATUS, rd);
    chk(rd, 8'h00);
    u_host.rd_reg(8'h05, rd);
    chk(rd, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_config();
    logic [7:0] addr_t [5] = '{8'h09, 8'h10, 8'h11, 8'h12, 8'h13};
    logic [7:0] val_t  [5] = '{8'hB7, 8'h70, 8'h85, 8'hA5, 8'h3C};
    for (int i = 0; i < 5; i++) begin
      u_host.wr_reg(addr_t[i], val_t[i], i % 2);
    end
    chk(cfg, {8'hB7, 8'h70, 8'h85, 8'hA5, 8'h3C});
    for (int i = 0; i < 5; i++) begin
      u_host.rd_reg(addr_t[i], rd);
      chk(rd, val_t[i]);
    end
    chk(out_en, 1'b0);
    $display("test config done");
  endtask

  // Two on-demand cycles; the first also checks low battery and a warning
  task automatic t_ondemand();
    for (int i = 0; i < 2; i++) begin
      u_host.wr_reg(`EBM_ADDR_MODE, 8'h01, 0);
      cyc(2);
      chk({state, out_en, ready_pin}, {EBM_ST_CHARGE, 2'b00});
      analog_in.cap_charged = 1'b1;
      cyc(3);
      chk({state, out_en, ready_pin}, {EBM_ST_ACTIVE, 2'b11});
      analog_in.cap_charged = 1'b0;
      u_host.rd_reg(`EBM_ADDR_STATUS, rd);
      chk(rd[0], 1'b1);
      if (i == 0) begin
        analog_in.battery_low = 1'b1;
        cyc(2);
        u_host.rd_reg(`EBM_ADDR_STATUS, rd);
        chk({rd[3], state}, {1'b1, EBM_ST_ACTIVE});
        analog_in.battery_low = 1'b0;
        analog_in.depletion_warning = 1'b1;
        cyc(2);
        chk(ready_pin, 1'b0);
        u_host.rd_reg(`EBM_ADDR_STATUS, rd);
        chk(rd[1], 1'b1);
        analog_in.depletion_warning = 1'b0;
      end
      u_host.wr_reg(`EBM_ADDR_MODE, 8'h00, 1);
      chk({state, out_en}, {EBM_ST_STANDBY, 1'b0});
      u_host.rd_reg(`EBM_ADDR_STATUS, rd);
      chk(rd[2:1], 2'b00);
    end
    $display("test on-demand done");
  endtask

  // Continuous: refresh via 010b, then alarm and warning together
  task automatic t_continuous();
    u_host.wr_reg(`EBM_ADDR_BATT_CFG, 8'h60, 0);
    u_host.wr_reg(`EBM_ADDR_MODE, 8'h02, 0);
    for (int i = 0; i < 2; i++) begin
      cyc(1);
      chk({state, out_en}, {EBM_ST_CHARGE, 1'b1});
      analog_in.cap_charged = 1'b1;
      cyc(3);
      chk({state, ready_pin}, {EBM_ST_READY, 1'b1});
      analog_in.cap_charged = 1'b0;
      u_host.wr_reg(`EBM_ADDR_MODE, 8'h06, 1);
      chk({state, ready_pin}, {EBM_ST_ACTIVE, 1'b1});
      if (i == 0) begin
        u_host.wr_reg(`EBM_ADDR_MODE, 8'h02, 0);
      end
    end
    analog_in.regulation_lost = 1'b1;
    analog_in.depletion_warning = 1'b1;
    cyc(2);
    u_host.rd_reg(`EBM_ADDR_STATUS, rd);
    chk({rd[2:1], ready_pin}, 3'b110);
    analog_in = '0;
    u_host.wr_reg(`EBM_ADDR_MODE, 8'h00, 1);
    chk(state, EBM_ST_STANDBY);
    $display("test continuous done");
  endtask

  // -----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // -----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    rst_n = 1'b0;
    analog_in = '0;
    cyc(8);
    rst_n = 1'b1;
    cyc(1);
    u_host.boot_wait();
    t_reset();
    t_config();
    t_ondemand();
    t_continuous();
    wrap_up();
  end

  // About 130 cycles are needed; the limit leaves wide margin
  initial begin
    #(40 * 5000);
    error_cnt++;
    wrap_up();
  end
endmodule
